// File: common/ccd_consts.svh
// offsets, field positions, reset values and timing counts of the clear/direction block
`ifndef CCD_CONSTS_SVH
`define CCD_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CCD_ADDR_CONFIG 8'h00
`define CCD_ADDR_FIRST_THRESHOLD 8'h04
`define CCD_ADDR_SECOND_THRESHOLD 8'h08
`define CCD_ADDR_PRIMARY_COUNT 8'h0C
`define CCD_ADDR_CYCLE_COUNT 8'h10
`define CCD_ADDR_TOTAL_COUNT 8'h14
`define CCD_ADDR_STATUS 8'h18

// ----------------------------------------
// config word fields
// ----------------------------------------
`define CCD_CFG_AUTO_ZERO 0
`define CCD_CFG_SEGMENT 1
`define CCD_CFG_SENSE_REV 2
`define CCD_CFG_PRIMARY_SRC_LO 4
`define CCD_CFG_CYCLE_SRC_LO 6
`define CCD_CFG_TOTAL_SRC_LO 8
`define CCD_CFG_FUNC_A_LO 12
`define CCD_CFG_FUNC_B_LO 16

// ----------------------------------------
// status word fields
// ----------------------------------------
`define CCD_STAT_AGREE 0
`define CCD_STAT_LEVEL_A 1
`define CCD_STAT_LEVEL_B 2
`define CCD_STAT_ARMED 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define CCD_RST_CONFIG 32'h0000_02A0
`define CCD_RST_THRESHOLD 32'h0000_0000
`define CCD_RST_COUNT 32'h0000_0000
`define CCD_ZERO_WORD 32'h0000_0000

// ----------------------------------------
// timing
// ----------------------------------------
`define CCD_MIN_ACTIVE_CYCLES 100000
`define CCD_FILT_CNT_W 20

`endif

// File: common/ccd_pkg.sv
// types of the clear/direction block
package ccd_pkg;

   // ----------------------------------------
   // selectors
   // ----------------------------------------
   typedef enum logic [1:0] {
      key_only_clear = 2'h0,
      input_only_clear = 2'h1,
      both_clear = 2'h2,
      no_clear = 2'h3
   } ccd_src_type;

   typedef enum logic [3:0] {
      input_off = 4'h0,
      clear_primary = 4'h1,
      clear_cycle = 4'h2,
      clear_primary_and_cycle = 4'h3,
      clear_total = 4'h4,
      clear_primary_and_total = 4'h5,
      clear_cycle_and_total = 4'h6,
      clear_every_counter = 4'h7,
      direction_ctrl = 4'h8
   } ccd_func_type;

   typedef enum logic [1:0] {
      key_idle = 2'b01,
      key_armed = 2'b10
   } ccd_key_type;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic auto_zero_enable;
      logic segment_mode;
      logic count_sense_reverse;
      ccd_src_type primary_clear_sources;
      ccd_src_type cycle_clear_sources;
      ccd_src_type total_clear_sources;
      ccd_func_type func_a;
      ccd_func_type func_b;
   } ccd_cfg_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ccd_bus_type;

   typedef struct packed {
      logic primary;
      logic cycle;
      logic total;
   } ccd_clears_type;

   typedef struct packed {
      logic s1;
      logic s2;
      logic level;
      logic fire;
      logic [19:0] cnt;
   } ccd_filt_type;

   typedef struct packed {
      ccd_cfg_type cfg;
      logic signed [31:0] first_threshold;
      logic signed [31:0] second_threshold;
      logic signed [31:0] primary_count;
      logic signed [31:0] cycle_count;
      logic signed [31:0] total_count;
      ccd_key_type key;
      logic reset_s1;
      logic reset_s2;
      logic reset_prev;
      logic enter_s1;
      logic enter_s2;
      logic enter_prev;
      logic agree;
      ccd_clears_type cleared;
      logic [31:0] rd_data;
   } ccd_state_type;

endpackage

// File: hdl/ccd_input_filter.sv
// synchroniser and minimum-width qualifier for one programmable input
`timescale 1ns/1ps
`include "ccd_consts.svh"

module ccd_input_filter #(
   parameter int MIN_CYCLES = `CCD_MIN_ACTIVE_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_pin,
   output logic o_level,
   output logic o_fire
);
   import ccd_pkg::*;

   ccd_filt_type st;
   ccd_filt_type next_st;

   if (MIN_CYCLES < 1 || MIN_CYCLES >= (1 << `CCD_FILT_CNT_W) - 1) begin : g_chk
      $error("ccd_input_filter: MIN_CYCLES out of range");
   end

   // ----------------------------------------
   // qualification
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_st.s1 = i_pin;
      next_st.s2 = st.s1;
      next_st.fire = 1'b0;
      if (!st.s2) begin
         next_st.cnt = '0;
         next_st.level = 1'b0;
      end else if (st.cnt < `CCD_FILT_CNT_W'(MIN_CYCLES)) begin
         next_st.cnt = st.cnt + 1'b1;
      end else if (!st.level) begin
         // one pulse per assertion
         next_st.level = 1'b1;
         next_st.fire = 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_level = st.level;
   assign o_fire = st.fire;
endmodule

// File: hdl/ccd_clear_ctrl.sv
// counter clearing and counting-direction control with its register port
//
// Contract
// - standard mode: auto-zero clears primary at first threshold
// - segment mode: auto-zero clears cycles at second threshold
// - segment mode: primary auto-zero always on
// - auto-zero setting is a single on/off bit
// - three clear-source selectors, four choices each
// - key-only: reset key then enter confirms clear
// - input clear after active level over 1 ms
// - input-only choice ignores front-panel key
// - both choice accepts key and input clears
// - none choice ignores key and input
// - remote write of zero clears unless none
// - each programmable input has function selector
// - input clears need input enabled in selector
// - direction is xnor of two direction inputs (or the one input) xored with sense
// - two direction inputs: equal agrees when forward
// - one direction input: active agrees when forward
// - count sense forward follows phase, reverse opposes
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "ccd_consts.svh"

module ccd_clear_ctrl #(
   parameter int MIN_ACTIVE_CYCLES = `CCD_MIN_ACTIVE_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire ccd_pkg::ccd_bus_type i_bus,
   output logic [31:0] o_rd_data,
   input wire logic i_step,
   input wire logic i_step_fwd,
   input wire logic i_reset_key,
   input wire logic i_enter_key,
   input wire logic i_prog_input_a,
   input wire logic i_prog_input_b,
   output logic signed [31:0] o_primary_count,
   output logic signed [31:0] o_cycle_count,
   output logic signed [31:0] o_total_count,
   output logic o_count_agree,
   output ccd_pkg::ccd_clears_type o_cleared
);
   import ccd_pkg::*;

   ccd_state_type st;
   ccd_state_type next_st;
   logic level_a;
   logic level_b;
   logic fire_a;
   logic fire_b;

   if (MIN_ACTIVE_CYCLES < 1) begin : g_chk
      $error("ccd_clear_ctrl: MIN_ACTIVE_CYCLES must be positive");
   end

   // ----------------------------------------
   // programmable input qualifiers
   // ----------------------------------------
   ccd_input_filter #(
      .MIN_CYCLES(MIN_ACTIVE_CYCLES)
   ) u_filter_a (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_pin(i_prog_input_a),
      .o_level(level_a),
      .o_fire(fire_a)
   );

   ccd_input_filter #(
      .MIN_CYCLES(MIN_ACTIVE_CYCLES)
   ) u_filter_b (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_pin(i_prog_input_b),
      .o_level(level_b),
      .o_fire(fire_b)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // unknown function codes fall back to an idle input
   function automatic ccd_func_type to_func(input logic [3:0] code);
      ccd_func_type f;
      f = input_off;
      if (code <= 4'h8) begin
         f = ccd_func_type'(code);
      end
      return f;
   endfunction

   function automatic ccd_cfg_type cfg_from_word(input logic [31:0] w);
      ccd_cfg_type c;
      c.auto_zero_enable = w[`CCD_CFG_AUTO_ZERO];
      c.segment_mode = w[`CCD_CFG_SEGMENT];
      c.count_sense_reverse = w[`CCD_CFG_SENSE_REV];
      c.primary_clear_sources = ccd_src_type'(w[`CCD_CFG_PRIMARY_SRC_LO +: 2]);
      c.cycle_clear_sources = ccd_src_type'(w[`CCD_CFG_CYCLE_SRC_LO +: 2]);
      c.total_clear_sources = ccd_src_type'(w[`CCD_CFG_TOTAL_SRC_LO +: 2]);
      c.func_a = to_func(w[`CCD_CFG_FUNC_A_LO +: 4]);
      c.func_b = to_func(w[`CCD_CFG_FUNC_B_LO +: 4]);
      return c;
   endfunction

   function automatic logic [31:0] cfg_to_word(input ccd_cfg_type c);
      logic [31:0] w;
      w = `CCD_ZERO_WORD;
      w[`CCD_CFG_AUTO_ZERO] = c.auto_zero_enable;
      w[`CCD_CFG_SEGMENT] = c.segment_mode;
      w[`CCD_CFG_SENSE_REV] = c.count_sense_reverse;
      w[`CCD_CFG_PRIMARY_SRC_LO +: 2] = c.primary_clear_sources;
      w[`CCD_CFG_CYCLE_SRC_LO +: 2] = c.cycle_clear_sources;
      w[`CCD_CFG_TOTAL_SRC_LO +: 2] = c.total_clear_sources;
      w[`CCD_CFG_FUNC_A_LO +: 4] = c.func_a;
      w[`CCD_CFG_FUNC_B_LO +: 4] = c.func_b;
      return w;
   endfunction

   // which counters a clearing input function names
   function automatic ccd_clears_type func_targets(input ccd_func_type f);
      ccd_clears_type t;
      t = '0;
      case (f)
         clear_primary: begin
            t.primary = 1'b1;
         end
         clear_cycle: begin
            t.cycle = 1'b1;
         end
         clear_primary_and_cycle: begin
            t.primary = 1'b1;
            t.cycle = 1'b1;
         end
         clear_total: begin
            t.total = 1'b1;
         end
         clear_primary_and_total: begin
            t.primary = 1'b1;
            t.total = 1'b1;
         end
         clear_cycle_and_total: begin
            t.cycle = 1'b1;
            t.total = 1'b1;
         end
         clear_every_counter: begin
            t = '1;
         end
         default: begin
            t = '0;
         end
      endcase
      return t;
   endfunction

   function automatic logic key_allowed(input ccd_src_type s);
      return (s == key_only_clear) || (s == both_clear);
   endfunction

   function automatic logic input_allowed(input ccd_src_type s);
      return (s == input_only_clear) || (s == both_clear);
   endfunction

   // one clear per counter however many sources ask
   function automatic logic clear_wanted(input ccd_src_type s, input logic key_req,
                                         input logic in_req, input logic remote_req);
      return (key_req && key_allowed(s))
          || (in_req && input_allowed(s))
          || (remote_req && (s != no_clear));
   endfunction

   // 1 means counting with the quadrature phase
   function automatic logic agree_dir(input ccd_cfg_type c, input logic la, input logic lb);
      logic dir_a;
      logic dir_b;
      logic agree;
      dir_a = (c.func_a == direction_ctrl);
      dir_b = (c.func_b == direction_ctrl);
      if (dir_a && dir_b) begin
         agree = ~(la ^ lb);
      end else if (dir_a) begin
         agree = la;
      end else if (dir_b) begin
         agree = lb;
      end else begin
         agree = 1'b1;
      end
      return agree ^ c.count_sense_reverse;
   endfunction

   function automatic logic signed [31:0] step_value(input logic signed [31:0] v,
                                                     input logic up);
      return up ? v + 32'sd1 : v - 32'sd1;
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic reset_rise;
      logic enter_rise;
      logic key_confirm;
      logic up;
      logic auto_primary;
      logic auto_cycle;
      logic cycle_step;
      ccd_clears_type in_req;
      ccd_clears_type remote_req;
      ccd_clears_type clr;

      reset_rise = 1'b0;
      enter_rise = 1'b0;
      key_confirm = 1'b0;
      up = 1'b0;
      auto_primary = 1'b0;
      auto_cycle = 1'b0;
      cycle_step = 1'b0;
      in_req = '0;
      remote_req = '0;
      clr = '0;
      next_st = st;

      // key synchronisers; edges taken from the second stage only
      next_st.reset_s1 = i_reset_key;
      next_st.reset_s2 = st.reset_s1;
      next_st.reset_prev = st.reset_s2;
      next_st.enter_s1 = i_enter_key;
      next_st.enter_s2 = st.enter_s1;
      next_st.enter_prev = st.enter_s2;
      reset_rise = st.reset_s2 && !st.reset_prev;
      enter_rise = st.enter_s2 && !st.enter_prev;

      // reset key only arms; nothing clears until enter confirms
      case (st.key)
         key_idle: begin
            if (reset_rise) begin
               next_st.key = key_armed;
            end
         end
         key_armed: begin
            if (enter_rise) begin
               key_confirm = 1'b1;
               next_st.key = key_idle;
            end
         end
         default: begin
            next_st.key = key_idle;
         end
      endcase

      // clearing inputs
      if (fire_a) begin
         in_req = in_req | func_targets(st.cfg.func_a);
      end
      if (fire_b) begin
         in_req = in_req | func_targets(st.cfg.func_b);
      end

      // remote zeroing: only a zero word clears, other values are ignored
      if (i_bus.wr && (i_bus.wdata == `CCD_ZERO_WORD)) begin
         remote_req.primary = (i_bus.addr == `CCD_ADDR_PRIMARY_COUNT);
         remote_req.cycle = (i_bus.addr == `CCD_ADDR_CYCLE_COUNT);
         remote_req.total = (i_bus.addr == `CCD_ADDR_TOTAL_COUNT);
      end

      // automatic zeroing on threshold match
      auto_primary = (st.cfg.segment_mode || st.cfg.auto_zero_enable)
         && (st.primary_count == st.first_threshold);
      auto_cycle = st.cfg.segment_mode && st.cfg.auto_zero_enable
         && (st.cycle_count == st.second_threshold);

      clr.primary = auto_primary
         || clear_wanted(st.cfg.primary_clear_sources, key_confirm,
                         in_req.primary, remote_req.primary);
      clr.cycle = auto_cycle
         || clear_wanted(st.cfg.cycle_clear_sources, key_confirm,
                         in_req.cycle, remote_req.cycle);
      clr.total = clear_wanted(st.cfg.total_clear_sources, key_confirm,
                               in_req.total, remote_req.total);

      // direction
      next_st.agree = agree_dir(st.cfg, level_a, level_b);
      up = ~(i_step_fwd ^ st.agree);

      // counters: a clear wins over a step in the same cycle
      if (clr.primary) begin
         next_st.primary_count = `CCD_RST_COUNT;
      end else if (i_step) begin
         next_st.primary_count = step_value(st.primary_count, up);
      end

      // standard mode counts automatic primary wraps; segment mode counts length
      cycle_step = st.cfg.segment_mode ? i_step : auto_primary;
      if (clr.cycle) begin
         next_st.cycle_count = `CCD_RST_COUNT;
      end else if (cycle_step) begin
         next_st.cycle_count = step_value(st.cycle_count, st.cfg.segment_mode ? up : 1'b1);
      end

      if (clr.total) begin
         next_st.total_count = `CCD_RST_COUNT;
      end else if (i_step) begin
         next_st.total_count = step_value(st.total_count, up);
      end
      next_st.cleared = clr;

      // register writes
      if (i_bus.wr) begin
         case (i_bus.addr)
            `CCD_ADDR_CONFIG: begin
               next_st.cfg = cfg_from_word(i_bus.wdata);
            end
            `CCD_ADDR_FIRST_THRESHOLD: begin
               next_st.first_threshold = i_bus.wdata;
            end
            `CCD_ADDR_SECOND_THRESHOLD: begin
               next_st.second_threshold = i_bus.wdata;
            end
            default: begin
            end
         endcase
      end

      // read data stands for exactly one cycle
      next_st.rd_data = `CCD_ZERO_WORD;
      if (i_bus.rd) begin
         case (i_bus.addr)
            `CCD_ADDR_CONFIG: begin
               next_st.rd_data = cfg_to_word(st.cfg);
            end
            `CCD_ADDR_FIRST_THRESHOLD: begin
               next_st.rd_data = st.first_threshold;
            end
            `CCD_ADDR_SECOND_THRESHOLD: begin
               next_st.rd_data = st.second_threshold;
            end
            `CCD_ADDR_PRIMARY_COUNT: begin
               next_st.rd_data = st.primary_count;
            end
            `CCD_ADDR_CYCLE_COUNT: begin
               next_st.rd_data = st.cycle_count;
            end
            `CCD_ADDR_TOTAL_COUNT: begin
               next_st.rd_data = st.total_count;
            end
            `CCD_ADDR_STATUS: begin
               next_st.rd_data[`CCD_STAT_AGREE] = st.agree;
               next_st.rd_data[`CCD_STAT_LEVEL_A] = level_a;
               next_st.rd_data[`CCD_STAT_LEVEL_B] = level_b;
               next_st.rd_data[`CCD_STAT_ARMED] = (st.key == key_armed);
            end
            default: begin
               next_st.rd_data = `CCD_ZERO_WORD;
            end
         endcase
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st <= '0;
         st.cfg <= cfg_from_word(`CCD_RST_CONFIG);
         st.first_threshold <= `CCD_RST_THRESHOLD;
         st.second_threshold <= `CCD_RST_THRESHOLD;
         st.key <= key_idle;
         st.agree <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_rd_data = st.rd_data;
   assign o_primary_count = st.primary_count;
   assign o_cycle_count = st.cycle_count;
   assign o_total_count = st.total_count;
   assign o_count_agree = st.agree;
   assign o_cleared = st.cleared;
endmodule

// File: tb/ccd_clear_ctrl_asserts.sv
// port-level checks of the clear/direction block
`timescale 1ns/1ps
`include "ccd_consts.svh"

module ccd_clear_ctrl_asserts
   import ccd_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire ccd_pkg::ccd_bus_type i_bus,
   input wire logic i_step,
   input wire logic i_step_fwd,
   input wire logic signed [31:0] o_primary_count,
   input wire logic signed [31:0] o_cycle_count,
   input wire logic signed [31:0] o_total_count,
   input wire logic o_count_agree,
   input wire ccd_pkg::ccd_clears_type o_cleared
);
   // ----------------------------------------
   // config shadow
   // ----------------------------------------
   logic [31:0] cfg_q;
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cfg_q <= `CCD_RST_CONFIG;
      end else if (i_bus.wr && i_bus.addr == `CCD_ADDR_CONFIG) begin
         cfg_q <= i_bus.wdata;
      end
   end

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);

   // ----------------------------------------
   // properties
   // ----------------------------------------
   sequence s_zero_write(logic [7:0] a, logic [1:0] src);
      i_bus.wr && i_bus.addr == a && i_bus.wdata == `CCD_ZERO_WORD && src != 2'h3;
   endsequence
   property p_remote_primary;
      s_zero_write(`CCD_ADDR_PRIMARY_COUNT, cfg_q[5:4])
         |=> o_cleared.primary && o_primary_count == 0;
   endproperty
   property p_remote_cycle;
      s_zero_write(`CCD_ADDR_CYCLE_COUNT, cfg_q[7:6]) |=> o_cleared.cycle && o_cycle_count == 0;
   endproperty
   property p_remote_total;
      s_zero_write(`CCD_ADDR_TOTAL_COUNT, cfg_q[9:8]) |=> o_cleared.total && o_total_count == 0;
   endproperty
   property p_clear_wins;
      o_cleared.primary |-> o_primary_count == 0;
   endproperty
   // stable guard: agree is registered one cycle behind the config
   property p_agree_plain;
      $stable(cfg_q) && cfg_q[15:12] != 4'h8 && cfg_q[19:16] != 4'h8
         |-> o_count_agree == !cfg_q[2];
   endproperty
   property p_none_blocks;
      $stable(cfg_q) && cfg_q[5:4] == 2'h3 && cfg_q[1:0] == 2'h0 |-> !o_cleared.primary;
   endproperty
   property p_step_up;
      i_step && (i_step_fwd ~^ o_count_agree)
         |=> o_cleared.total || o_total_count == $past(o_total_count) + 1;
   endproperty
   property p_step_down;
      i_step && (i_step_fwd ^ o_count_agree)
         |=> o_cleared.total || o_total_count == $past(o_total_count) - 1;
   endproperty

   a_remote_primary: assert property (p_remote_primary) else $error("primary zero write lost");
   a_remote_cycle: assert property (p_remote_cycle) else $error("cycle zero write lost");
   a_remote_total: assert property (p_remote_total) else $error("total zero write lost");
   a_clear_wins: assert property (p_clear_wins) else $error("clear pulse without zero");
   a_agree_plain: assert property (p_agree_plain) else $error("agree not sense");
   a_none_blocks: assert property (p_none_blocks) else $error("primary cleared under none");
   a_step_up: assert property (p_step_up) else $error("total did not count up");
   a_step_down: assert property (p_step_down) else $error("total did not count down");
endmodule

bind ccd_clear_ctrl ccd_clear_ctrl_asserts u_clear_ctrl_asserts (
   .i_clock(i_clock),
   .i_sys_rst(i_sys_rst),
   .i_bus(i_bus),
   .i_step(i_step),
   .i_step_fwd(i_step_fwd),
   .o_primary_count(o_primary_count),
   .o_cycle_count(o_cycle_count),
   .o_total_count(o_total_count),
   .o_count_agree(o_count_agree),
   .o_cleared(o_cleared)
);

// File: tb/ccd_panel_model.sv
// front-panel keys and programmable input sources
`timescale 1ns/1ps

module ccd_panel_model (
   input wire logic i_clock,
   output logic o_reset_key,
   output logic o_enter_key,
   output logic o_prog_input_a,
   output logic o_prog_input_b
);
   // pins idle low, as with a pull-down
   initial begin
      {o_reset_key, o_enter_key, o_prog_input_a, o_prog_input_b} = 4'h0;
   end
   // one operator press; enter only confirms an armed reset
   task automatic press(input logic enter);
      @(posedge i_clock);
      {o_enter_key, o_reset_key} <= {enter, !enter};
      repeat (6) @(posedge i_clock);
      {o_enter_key, o_reset_key} <= 2'h0;
      repeat (6) @(posedge i_clock);
   endtask
   task automatic level(input logic sel, input logic v);
      @(posedge i_clock);
      {o_prog_input_b, o_prog_input_a} <= sel ? {v, o_prog_input_a} : {o_prog_input_b, v};
   endtask
   // short widths on purpose too
   task automatic pulse(input logic sel, input int cycles);
      level(sel, 1'b1);
      repeat (cycles) @(posedge i_clock);
      level(sel, 1'b0);
      repeat (6) @(posedge i_clock);
   endtask
endmodule

// File: tb/ccd_clear_ctrl_bench.sv
// self-checking bench of the clear/direction block
`timescale 1ns/1ps
`include "ccd_consts.svh"

module ccd_clear_ctrl_bench;
   import ccd_pkg::*;
   localparam int MIN_CYC = 8;
   logic i_clock = 1'b0;
   logic i_sys_rst = 1'b1;
   ccd_bus_type bus = '0;
   logic step = 1'b0, step_fwd = 1'b1;
   logic reset_key, enter_key, in_a, in_b;
   logic [31:0] rd_data;
   logic signed [31:0] p_cnt, c_cnt, t_cnt;
   logic agree;
   ccd_clears_type cleared;
   logic signed [31:0] exp_p = '0, exp_c = '0, exp_t = '0;
   logic exp_agree = 1'b1, seg = 1'b0;
   logic [31:0] d;
   int miscompares = 0, checks = 0, cycles = 0;

   always #5 i_clock = ~i_clock;

   ccd_clear_ctrl #(.MIN_ACTIVE_CYCLES(MIN_CYC)) DUT (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_bus(bus),
      .o_rd_data(rd_data),
      .i_step(step),
      .i_step_fwd(step_fwd),
      .i_reset_key(reset_key),
      .i_enter_key(enter_key),
      .i_prog_input_a(in_a),
      .i_prog_input_b(in_b),
      .o_primary_count(p_cnt),
      .o_cycle_count(c_cnt),
      .o_total_count(t_cnt),
      .o_count_agree(agree),
      .o_cleared(cleared)
   );
   ccd_panel_model PANEL (
      .i_clock(i_clock),
      .o_reset_key(reset_key),
      .o_enter_key(enter_key),
      .o_prog_input_a(in_a),
      .o_prog_input_b(in_b)
   );

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clock);
      bus <= {a, v, 2'b10};
      @(posedge i_clock);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_clock);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge i_clock);
      bus.rd <= 1'b0;
      #1 d = rd_data;
   endtask
   // mode is {sense_rev, segment, auto_zero}; srcs {total, cycle, primary}
   task automatic setcfg(input logic [2:0] mode, input logic [5:0] srcs, input logic [7:0] fn);
      wr(`CCD_ADDR_CONFIG, {12'h000, fn, 2'h0, srcs, 1'b0, mode});
      seg = mode[1];
   endtask
   task automatic steps(input int n, input logic fwd);
      int inc;
      inc = (fwd == exp_agree) ? n : -n;
      exp_p = exp_p + inc;
      exp_t = exp_t + inc;
      if (seg) begin
         exp_c = exp_c + inc;
      end
      @(posedge i_clock);
      step <= 1'b1;
      step_fwd <= fwd;
      repeat (n) @(posedge i_clock);
      step <= 1'b0;
      idle(2);
   endtask
   task automatic chk_counts;
      chk(p_cnt, exp_p);
      chk(c_cnt, exp_c);
      chk(t_cnt, exp_t);
   endtask

   // ----------------------------------------
   // timeout
   // ----------------------------------------
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      idle(4);
      i_sys_rst <= 1'b0;
      rd(`CCD_ADDR_CONFIG);
      chk(d, `CCD_RST_CONFIG);
      rd(8'h1C);
      chk(d, 32'h0000_0000);
      steps(5, 1'b1);
      chk_counts();
      wr(`CCD_ADDR_PRIMARY_COUNT, 32'h0000_0000);
      wr(`CCD_ADDR_TOTAL_COUNT, 32'h0000_0005);
      exp_p = 0;
      idle(1);
      chk_counts();
      // primary key only, cycle both, total none
      setcfg(3'h0, 6'b11_10_00, 8'h00);
      steps(3, 1'b1);
      PANEL.press(1'b1);
      chk_counts();
      PANEL.press(1'b0);
      PANEL.press(1'b1);
      wr(`CCD_ADDR_TOTAL_COUNT, 32'h0000_0000);
      exp_p = 0;
      idle(2);
      chk_counts();
      // primary input only, input a clears primary
      setcfg(3'h0, 6'b10_10_01, 8'h01);
      steps(2, 1'b1);
      PANEL.press(1'b0);
      PANEL.press(1'b1);
      exp_t = 0;
      chk_counts();
      PANEL.pulse(1'b0, MIN_CYC - 4);
      chk_counts();
      fork
         PANEL.pulse(1'b0, 5 * MIN_CYC);
         begin
            idle(3 * MIN_CYC);
            steps(2, 1'b1);
         end
      join
      exp_p = 2;
      chk_counts();
      // every clear function on input b
      wr(`CCD_ADDR_FIRST_THRESHOLD, 32'h0000_03E8);
      for (int f = 1; f < 8; f++) begin
         setcfg(3'h2, 6'b10_10_10, {f[3:0], 4'h0});
         steps(3, 1'b1);
         PANEL.pulse(1'b1, 3 * MIN_CYC);
         exp_p = f[0] ? 0 : exp_p;
         exp_c = f[1] ? 0 : exp_c;
         exp_t = f[2] ? 0 : exp_t;
         chk_counts();
      end
      // automatic zeroing at the thresholds
      for (int a = `CCD_ADDR_PRIMARY_COUNT; a < `CCD_ADDR_STATUS; a += 4) begin
         wr(8'(a), 32'h0000_0000);
      end
      wr(`CCD_ADDR_FIRST_THRESHOLD, 32'h0000_0003);
      wr(`CCD_ADDR_SECOND_THRESHOLD, 32'h0000_0005);
      {exp_p, exp_c, exp_t} = '0;
      steps(3, 1'b1);
      exp_p = 0;
      chk_counts();
      setcfg(3'h3, 6'b10_10_10, 8'h00);
      steps(2, 1'b1);
      exp_c = 0;
      chk_counts();
      setcfg(3'h1, 6'b10_10_10, 8'h00);
      steps(1, 1'b1);
      exp_p = 0;
      exp_c = 1;
      chk_counts();
      // direction from the inputs
      setcfg(3'h0, 6'b10_10_10, 8'h08);
      PANEL.level(1'b0, 1'b1);
      idle(2 * MIN_CYC);
      chk(agree, 1'b1);
      PANEL.level(1'b0, 1'b0);
      idle(6);
      chk(agree, 1'b0);
      exp_agree = 1'b0;
      steps(1, 1'b1);
      chk_counts();
      setcfg(3'h4, 6'b10_10_10, 8'h88);
      idle(3);
      chk(agree, 1'b0);
      PANEL.level(1'b1, 1'b1);
      idle(2 * MIN_CYC);
      chk(agree, 1'b1);
      conclude();
   end
endmodule
